// [hw/tmb_pkg.sv]
// Constants shared by the timer 2 status and polarity block.
// Assumes an 8-bit register port on the system clock.
package tmb_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int FLAG_N = 4;

  // Register offsets
  localparam logic [7:0] OFS_CTRL_B = 8'h0b;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h11;
  localparam logic [7:0] OFS_LIVE_VIEW = 8'h12;

  // Control register B fields
  localparam int BIT_LOW_CMP = 0;
  localparam int BIT_CAP_CMP = 1;
  localparam int BIT_LOW_OVF = 2;
  localparam int BIT_MAIN_OVF = 3;
  localparam int BIT_RESERVED = 4;
  localparam int BIT_SEC_POL = 5;
  localparam int BIT_SEC_OE = 6;
  localparam int BIT_LOW_IE = 7;

  // Live view fields
  localparam int BIT_VIEW_MODE = 0;
  localparam int BIT_VIEW_PIN = 1;
  localparam int BIT_VIEW_CAP_PIN = 2;

  // Reset values and flag mask
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;
  localparam logic [3:0] FLAG_MASK_ALL = 4'hf;
endpackage

// [hw/tmb_evt_if.sv]
// Event pulses passed from the match detector to the flag and pin logic.
// All signals are one-cycle pulses on the system clock.
`timescale 1ns/1ps
interface tmb_evt_if;
  logic low_cmp_evt;
  logic cap_cmp_evt;
  logic low_ovf_evt;
  logic main_ovf_evt;
  logic alt_src_evt;

  modport gen (
    output low_cmp_evt,
    output cap_cmp_evt,
    output low_ovf_evt,
    output main_ovf_evt,
    output alt_src_evt
  );
  modport use_evt (
    input low_cmp_evt,
    input cap_cmp_evt,
    input low_ovf_evt,
    input main_ovf_evt,
    input alt_src_evt
  );
endinterface

// [hw/tmb_evt_gen.sv]
// Turns counter state and overflow strobes into event pulses per width mode.
// Assumes the counter datapath runs on the same clock.
`timescale 1ns/1ps
module tmb_evt_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dual_byte_mode_select,
  input wire logic [tmb_pkg::CNT_W-1:0] counter_value,
  input wire logic [tmb_pkg::CNT_W-1:0] compare_value,
  input wire logic [tmb_pkg::BYTE_W-1:0] high_compare_value,
  input wire logic [tmb_pkg::BYTE_W-1:0] low_compare_value,
  input wire logic full_ovf,
  input wire logic high_ovf,
  input wire logic low_ovf,
  tmb_evt_if.gen evt
);
  logic low_eq;
  logic cap_eq;
  logic low_eq_d;
  logic cap_eq_d;

  // Only dual mode has a low comparator
  assign low_eq = dual_byte_mode_select &&
                  (counter_value[tmb_pkg::BYTE_W-1:0] == low_compare_value); // R2
  assign cap_eq = dual_byte_mode_select ?
                  (counter_value[tmb_pkg::CNT_W-1:tmb_pkg::BYTE_W] == high_compare_value) :
                  (counter_value == compare_value); // R4

  // A match counts once when it begins, not every cycle it holds
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_eq_d <= 1'b0;
      cap_eq_d <= 1'b0;
    end else begin
      low_eq_d <= low_eq;
      cap_eq_d <= cap_eq;
    end
  end

  assign evt.low_cmp_evt = low_eq && !low_eq_d; // R2
  assign evt.cap_cmp_evt = cap_eq && !cap_eq_d; // R4
  assign evt.low_ovf_evt = dual_byte_mode_select && low_ovf; // R6
  assign evt.main_ovf_evt = dual_byte_mode_select ? high_ovf : full_ovf; // R7 R8
  assign evt.alt_src_evt = dual_byte_mode_select ? (low_ovf || evt.low_cmp_evt) :
                           (full_ovf || evt.cap_cmp_evt); // R11
endmodule

// [hw/tmb_alt_out.sv]
// Alternate output pin: starting level from the polarity bit, toggled by timer events.
// Assumes event pulses and control bits on the same clock.
`timescale 1ns/1ps
module tmb_alt_out (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic secondary_output_enable,
  input wire logic secondary_output_polarity,
  tmb_evt_if.use_evt evt,
  output logic pin_level,
  output logic pin_oe
);
  logic oe_d;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_d <= 1'b0;
    end else begin
      oe_d <= secondary_output_enable;
    end
  end

  // Polarity is sampled only on the enable's rising edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_level <= 1'b0;
    end else if (secondary_output_enable && !oe_d) begin
      pin_level <= secondary_output_polarity; // R10 R12
    end else if (secondary_output_enable && evt.alt_src_evt) begin
      pin_level <= ~pin_level; // R11
    end
  end

  assign pin_oe = secondary_output_enable; // R10
endmodule

// [hw/tmb_timer2_status.sv]
// Top of the timer 2 status and secondary output polarity block.
// Assumes a register port on REF_CLK_IN and a counter datapath on the same clock.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

// What this block does
// R1 - Control register B and all its flags clear to zero on every reset.
// R2 - Low compare flag sets only in dual mode on low-byte match.
// R3 - Low half has no capture; capture events never touch low flags.
// R4 - Capture/compare flag sets on full match, or high-byte match in dual mode.
// R5 - Capture/compare flag also sets on a rising external capture pin edge.
// R6 - Low overflow flag sets on low-byte overflow in dual mode only.
// R7 - In 16-bit mode main overflow flag sets on full counter overflow.
// R8 - In dual mode main overflow flag sets on high-byte overflow.
// R9 - Bit 4 reads zero and ignores writes.
// R10 - With secondary output enabled, polarity bit sets the pin starting level.
// R11 - Pin waveform follows full timer, or low-byte timer in dual mode.
// R12 - Polarity writes any time; pin takes them only on enable rising.
// R13 - Flags stay set until written zero; writing one sets them.
// R14 - Low interrupt request when low enable and low overflow or compare flag.
module tmb_timer2_status (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  // Register port
  input wire logic [tmb_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [tmb_pkg::DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [tmb_pkg::DATA_W-1:0] RDATA_OUT,
  // Counter datapath
  input wire logic DUAL_BYTE_MODE_SELECT_IN,
  input wire logic [tmb_pkg::CNT_W-1:0] COUNTER_VALUE_IN,
  input wire logic [tmb_pkg::CNT_W-1:0] COMPARE_VALUE_IN,
  input wire logic [tmb_pkg::BYTE_W-1:0] HIGH_COMPARE_VALUE_IN,
  input wire logic [tmb_pkg::BYTE_W-1:0] LOW_COMPARE_VALUE_IN,
  input wire logic FULL_OVF_IN,
  input wire logic HIGH_OVF_IN,
  input wire logic LOW_OVF_IN,
  // Capture
  input wire logic CAPTURE_ENABLE_IN,
  input wire logic CAPTURE_PIN_IN,
  output logic CAPTURE_STROBE_OUT,
  // Alternate output pin
  output logic ALTERNATE_OUTPUT_PIN_OUT,
  output logic ALTERNATE_OUTPUT_PIN_OE_OUT,
  // Interrupts
  output logic LOW_IRQ_OUT,
  output logic IRQ_OUT
);
  logic cap_meta;
  logic cap_sync;
  logic cap_sync_d;
  logic cap_edge;
  logic low_cmp_flag;
  logic capture_compare_flag;
  logic low_ovf_flag;
  logic main_ovf_flag;
  logic secondary_output_polarity;
  logic secondary_output_enable;
  logic low_interrupt_enable;
  logic [tmb_pkg::FLAG_N-1:0] hw_set;
  logic [tmb_pkg::FLAG_N-1:0] flags;
  logic [tmb_pkg::FLAG_N-1:0] irq_status;
  logic [tmb_pkg::FLAG_N-1:0] irq_mask;
  logic [tmb_pkg::DATA_W-1:0] ctrl_b_view;
  logic [tmb_pkg::DATA_W-1:0] live_view;
  logic [tmb_pkg::DATA_W-1:0] next_rdata;
  logic wr_ctrl_b;
  logic wr_status;
  logic wr_mask;
  logic pin_level;
  logic pin_oe;

  tmb_evt_if evt ();

  // Capture pin is asynchronous: two flip-flops before any use
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      cap_meta <= 1'b0;
      cap_sync <= 1'b0;
    end else begin
      cap_meta <= CAPTURE_PIN_IN;
      cap_sync <= cap_meta;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      cap_sync_d <= 1'b0;
    end else begin
      cap_sync_d <= cap_sync;
    end
  end

  // Rising edge only; the neighbouring datapath loads the capture value
  assign cap_edge = CAPTURE_ENABLE_IN && cap_sync && !cap_sync_d;

  // Strobe to the datapath; its capture loads only the full/high value
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      CAPTURE_STROBE_OUT <= 1'b0;
    end else begin
      CAPTURE_STROBE_OUT <= cap_edge; // R3
    end
  end

  tmb_evt_gen u_evt_gen (
    .clk(REF_CLK_IN),
    .rst_n(NRST_IN),
    .dual_byte_mode_select(DUAL_BYTE_MODE_SELECT_IN),
    .counter_value(COUNTER_VALUE_IN),
    .compare_value(COMPARE_VALUE_IN),
    .high_compare_value(HIGH_COMPARE_VALUE_IN),
    .low_compare_value(LOW_COMPARE_VALUE_IN),
    .full_ovf(FULL_OVF_IN),
    .high_ovf(HIGH_OVF_IN),
    .low_ovf(LOW_OVF_IN),
    .evt(evt.gen)
  );

  // Hardware set sources, in control register B bit order
  always_comb begin
    hw_set = '0;
    hw_set[tmb_pkg::BIT_LOW_CMP] = evt.low_cmp_evt; // R2 R3
    hw_set[tmb_pkg::BIT_CAP_CMP] = evt.cap_cmp_evt || cap_edge; // R4 R5
    hw_set[tmb_pkg::BIT_LOW_OVF] = evt.low_ovf_evt; // R6
    hw_set[tmb_pkg::BIT_MAIN_OVF] = evt.main_ovf_evt; // R7 R8
  end

  // Register decode
  assign wr_ctrl_b = WR_IN && (ADDR_IN == tmb_pkg::OFS_CTRL_B);
  assign wr_status = WR_IN && (ADDR_IN == tmb_pkg::OFS_IRQ_STATUS);
  assign wr_mask = WR_IN && (ADDR_IN == tmb_pkg::OFS_IRQ_MASK);

  // Flag bits: a hardware event wins over a same-cycle write of zero
  genvar gi;
  generate
    for (gi = 0; gi < tmb_pkg::FLAG_N; gi++) begin : g_flag
      always_ff @(posedge REF_CLK_IN) begin
        if (!NRST_IN) begin
          flags[gi] <= tmb_pkg::RST_CTRL_B[gi]; // R1
        end else if (hw_set[gi]) begin
          flags[gi] <= 1'b1; // R13
        end else if (wr_ctrl_b) begin
          flags[gi] <= WDATA_IN[gi]; // R13
        end
      end
    end
  endgenerate

  assign low_cmp_flag = flags[tmb_pkg::BIT_LOW_CMP];
  assign capture_compare_flag = flags[tmb_pkg::BIT_CAP_CMP];
  assign low_ovf_flag = flags[tmb_pkg::BIT_LOW_OVF];
  assign main_ovf_flag = flags[tmb_pkg::BIT_MAIN_OVF];

  // Control bits of register B; bit 4 has no storage
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      secondary_output_polarity <= tmb_pkg::RST_CTRL_B[tmb_pkg::BIT_SEC_POL]; // R1
      secondary_output_enable <= tmb_pkg::RST_CTRL_B[tmb_pkg::BIT_SEC_OE]; // R1
      low_interrupt_enable <= tmb_pkg::RST_CTRL_B[tmb_pkg::BIT_LOW_IE]; // R1
    end else if (wr_ctrl_b) begin
      secondary_output_polarity <= WDATA_IN[tmb_pkg::BIT_SEC_POL]; // R12
      secondary_output_enable <= WDATA_IN[tmb_pkg::BIT_SEC_OE];
      low_interrupt_enable <= WDATA_IN[tmb_pkg::BIT_LOW_IE];
    end
  end

  // Sticky interrupt status, cleared by writing one; events win
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      irq_status <= tmb_pkg::RST_IRQ[tmb_pkg::FLAG_N-1:0];
    end else if (wr_status) begin
      irq_status <= (irq_status & ~WDATA_IN[tmb_pkg::FLAG_N-1:0]) | hw_set;
    end else begin
      irq_status <= irq_status | hw_set;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      irq_mask <= tmb_pkg::RST_IRQ[tmb_pkg::FLAG_N-1:0];
    end else if (wr_mask) begin
      irq_mask <= WDATA_IN[tmb_pkg::FLAG_N-1:0] & tmb_pkg::FLAG_MASK_ALL;
    end
  end

  assign IRQ_OUT = |(irq_status & irq_mask);
  assign LOW_IRQ_OUT = low_interrupt_enable && (low_ovf_flag || low_cmp_flag); // R14

  tmb_alt_out u_alt_out (
    .clk(REF_CLK_IN),
    .rst_n(NRST_IN),
    .secondary_output_enable(secondary_output_enable),
    .secondary_output_polarity(secondary_output_polarity),
    .evt(evt.use_evt),
    .pin_level(pin_level),
    .pin_oe(pin_oe)
  );

  assign ALTERNATE_OUTPUT_PIN_OUT = pin_level; // R10
  assign ALTERNATE_OUTPUT_PIN_OE_OUT = pin_oe; // R10

  // Read views
  always_comb begin
    ctrl_b_view = '0;
    ctrl_b_view[tmb_pkg::BIT_LOW_CMP] = low_cmp_flag;
    ctrl_b_view[tmb_pkg::BIT_CAP_CMP] = capture_compare_flag;
    ctrl_b_view[tmb_pkg::BIT_LOW_OVF] = low_ovf_flag;
    ctrl_b_view[tmb_pkg::BIT_MAIN_OVF] = main_ovf_flag;
    ctrl_b_view[tmb_pkg::BIT_RESERVED] = 1'b0; // R9
    ctrl_b_view[tmb_pkg::BIT_SEC_POL] = secondary_output_polarity;
    ctrl_b_view[tmb_pkg::BIT_SEC_OE] = secondary_output_enable;
    ctrl_b_view[tmb_pkg::BIT_LOW_IE] = low_interrupt_enable;
  end

  always_comb begin
    live_view = '0;
    live_view[tmb_pkg::BIT_VIEW_MODE] = DUAL_BYTE_MODE_SELECT_IN;
    live_view[tmb_pkg::BIT_VIEW_PIN] = pin_level;
    live_view[tmb_pkg::BIT_VIEW_CAP_PIN] = cap_sync;
  end

  // Unmapped addresses read as zero
  always_comb begin
    case (ADDR_IN)
      tmb_pkg::OFS_CTRL_B: next_rdata = ctrl_b_view;
      tmb_pkg::OFS_IRQ_STATUS: next_rdata = {{(tmb_pkg::DATA_W-tmb_pkg::FLAG_N){1'b0}}, irq_status};
      tmb_pkg::OFS_IRQ_MASK: next_rdata = {{(tmb_pkg::DATA_W-tmb_pkg::FLAG_N){1'b0}}, irq_mask};
      tmb_pkg::OFS_LIVE_VIEW: next_rdata = live_view;
      default: next_rdata = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      RDATA_OUT <= '0;
    end else if (RD_IN) begin
      RDATA_OUT <= next_rdata;
    end else begin
      RDATA_OUT <= '0;
    end
  end
endmodule

// [verif/tmb_timer2_status_sva.sv]
// Checker for the timer 2 status block, bound to its top module.
// Assumes the bench keeps counter and compare values apart during pin tests.
`timescale 1ns/1ps
module tmb_timer2_status_sva (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  // Register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  // Datapath and capture
  input wire logic DUAL_BYTE_MODE_SELECT_IN,
  input wire logic FULL_OVF_IN,
  input wire logic LOW_OVF_IN,
  input wire logic CAPTURE_ENABLE_IN,
  input wire logic CAPTURE_PIN_IN,
  input wire logic CAPTURE_STROBE_OUT,
  // Pin and interrupt
  input wire logic ALTERNATE_OUTPUT_PIN_OUT,
  input wire logic ALTERNATE_OUTPUT_PIN_OE_OUT,
  input wire logic LOW_IRQ_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data not zero outside a read");
  a_resv_bit: assert property ($past(RD_IN) && $past(ADDR_IN) == 8'h0b |-> !RDATA_OUT[4])
    else $error("reserved bit reads one");
  a_oe_set: assert property (WR_IN && ADDR_IN == 8'h0b && WDATA_IN[6] |=> ALTERNATE_OUTPUT_PIN_OE_OUT)
    else $error("output enable not taken from write");
  a_pin_start_hi: assert property (WR_IN && ADDR_IN == 8'h0b && WDATA_IN[6:5] == 2'b11
    && !ALTERNATE_OUTPUT_PIN_OE_OUT |=> ##1 ALTERNATE_OUTPUT_PIN_OUT)
    else $error("pin did not start high");
  a_pin_start_lo: assert property (WR_IN && ADDR_IN == 8'h0b && WDATA_IN[6:5] == 2'b10
    && !ALTERNATE_OUTPUT_PIN_OE_OUT |=> ##1 !ALTERNATE_OUTPUT_PIN_OUT)
    else $error("pin did not start low");
  a_pin_idle_hold: assert property (!ALTERNATE_OUTPUT_PIN_OE_OUT |=> $stable(ALTERNATE_OUTPUT_PIN_OUT))
    else $error("pin moved while disabled");
  a_tog_full: assert property (ALTERNATE_OUTPUT_PIN_OE_OUT && $past(ALTERNATE_OUTPUT_PIN_OE_OUT)
    && !DUAL_BYTE_MODE_SELECT_IN && FULL_OVF_IN |=> $changed(ALTERNATE_OUTPUT_PIN_OUT))
    else $error("pin missed full overflow");
  a_tog_low: assert property (ALTERNATE_OUTPUT_PIN_OE_OUT && $past(ALTERNATE_OUTPUT_PIN_OE_OUT)
    && DUAL_BYTE_MODE_SELECT_IN && LOW_OVF_IN |=> $changed(ALTERNATE_OUTPUT_PIN_OUT))
    else $error("pin missed low overflow");
  a_cap_strobe: assert property ($rose(CAPTURE_PIN_IN) && CAPTURE_ENABLE_IN |-> ##[2:6] CAPTURE_STROBE_OUT)
    else $error("capture strobe missing");
  a_low_irq_mode: assert property ($rose(LOW_IRQ_OUT) |-> $past(WR_IN) || $past(DUAL_BYTE_MODE_SELECT_IN))
    else $error("low interrupt outside dual mode");
endmodule

bind tmb_timer2_status tmb_timer2_status_sva i_sva (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .DUAL_BYTE_MODE_SELECT_IN(DUAL_BYTE_MODE_SELECT_IN), .FULL_OVF_IN(FULL_OVF_IN), .LOW_OVF_IN(LOW_OVF_IN),
  .CAPTURE_ENABLE_IN(CAPTURE_ENABLE_IN), .CAPTURE_PIN_IN(CAPTURE_PIN_IN), .CAPTURE_STROBE_OUT(CAPTURE_STROBE_OUT),
  .ALTERNATE_OUTPUT_PIN_OUT(ALTERNATE_OUTPUT_PIN_OUT), .ALTERNATE_OUTPUT_PIN_OE_OUT(ALTERNATE_OUTPUT_PIN_OE_OUT),
  .LOW_IRQ_OUT(LOW_IRQ_OUT));

// [verif/test_tmb_timer2_status.sv]
// Self-checking bench for the timer 2 status block.
// Assumes the checker is bound by its own file; counter inputs are driven here.
`timescale 1ns/1ps
module test_tmb_timer2_status;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, mode = 1'b0, cap_en = 1'b0, cap_pin = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, hcmp = 8'hff, lcmp = 8'hff;
  logic [15:0] cnt = 16'h0000, cmp = 16'hffff;
  // Overflow pulses: 2 full, 1 high, 0 low
  logic [2:0] ovf = 3'b000;
  wire logic [7:0] rdata;
  wire logic strobe, pin, oe, low_irq, irq;
  int error_cnt = 0;
  int n_compared = 0;

  always #20 clk = ~clk;

  tmb_timer2_status i_dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .DUAL_BYTE_MODE_SELECT_IN(mode), .COUNTER_VALUE_IN(cnt),
    .COMPARE_VALUE_IN(cmp), .HIGH_COMPARE_VALUE_IN(hcmp), .LOW_COMPARE_VALUE_IN(lcmp), .FULL_OVF_IN(ovf[2]),
    .HIGH_OVF_IN(ovf[1]), .LOW_OVF_IN(ovf[0]), .CAPTURE_ENABLE_IN(cap_en), .CAPTURE_PIN_IN(cap_pin),
    .CAPTURE_STROBE_OUT(strobe), .ALTERNATE_OUTPUT_PIN_OUT(pin), .ALTERNATE_OUTPUT_PIN_OE_OUT(oe),
    .LOW_IRQ_OUT(low_irq), .IRQ_OUT(irq));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, so it is sampled just past that edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  task automatic pulse(input int idx);
    @(posedge clk);
    ovf[idx] <= 1'b1;
    @(posedge clk);
    ovf <= 3'b000;
  endtask

  // A write and a full overflow in one cycle; the event must win over the write
  task automatic wr_evt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    ovf[2] <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    ovf <= 3'b000;
  endtask

  task automatic match(input logic [15:0] v);
    @(posedge clk);
    cnt <= v;
    @(posedge clk);
    cnt <= 16'h0000;
  endtask

  task automatic t_reset;
    #1 check({3'h0, oe, pin, low_irq, irq, strobe}, 8'h00);
    rd_chk(8'h0b, 8'h00);
    rd_chk(8'h10, 8'h00);
    wr_reg(8'h3c, 8'hff);
    rd_chk(8'h3c, 8'h00);
    wr_reg(8'h0b, 8'h1f);
    rd_chk(8'h0b, 8'h0f);
    repeat (4) @(posedge clk);
    rd_chk(8'h0b, 8'h0f);
    wr_reg(8'h0b, 8'h00);
    rd_chk(8'h0b, 8'h00);
    wr_reg(8'h10, 8'hff);
    $display("test reset done");
  endtask

  task automatic t_mode16;
    pulse(0);
    match(16'h00ff);
    pulse(2);
    match(16'hffff);
    repeat (3) @(posedge clk);
    rd_chk(8'h0b, 8'h0a);
    wr_evt(8'h0b, 8'h00);
    rd_chk(8'h0b, 8'h08);
    wr_evt(8'h10, 8'hff);
    rd_chk(8'h10, 8'h08);
    wr_reg(8'h0b, 8'h00);
    wr_reg(8'h10, 8'hff);
    $display("test mode16 done");
  endtask

  task automatic t_dual;
    mode <= 1'b1;
    wr_reg(8'h0b, 8'h80);
    #1 check({7'h00, low_irq}, 8'h00);
    pulse(0);
    rd_chk(8'h0b, 8'h84);
    check({7'h00, low_irq}, 8'h01);
    pulse(1);
    match(16'h00ff);
    match(16'hff00);
    repeat (3) @(posedge clk);
    rd_chk(8'h0b, 8'h8f);
    rd_chk(8'h10, 8'h0f);
    wr_reg(8'h11, 8'h04);
    #1 check({7'h00, irq}, 8'h01);
    rd_chk(8'h11, 8'h04);
    wr_reg(8'h10, 8'h04);
    #1 check({7'h00, irq}, 8'h00);
    wr_reg(8'h0b, 8'h80);
    #1 check({7'h00, low_irq}, 8'h00);
    wr_reg(8'h10, 8'hff);
    $display("test dual done");
  endtask

  task automatic t_capture;
    wr_reg(8'h0b, 8'h00);
    cap_en <= 1'b1;
    @(posedge clk);
    cap_pin <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check({7'h00, strobe}, 8'h00);
    @(posedge clk);
    #1 check({7'h00, strobe}, 8'h01);
    @(posedge clk);
    #1 check({7'h00, strobe}, 8'h00);
    rd_chk(8'h12, 8'h05);
    @(posedge clk);
    cap_pin <= 1'b0;
    rd_chk(8'h0b, 8'h02);
    cap_en <= 1'b0;
    mode <= 1'b0;
    wr_reg(8'h0b, 8'h00);
    $display("test capture done");
  endtask

  task automatic t_pin;
    wr_reg(8'h0b, 8'h60);
    repeat (2) @(posedge clk);
    #1 check({6'h00, oe, pin}, 8'h03);
    rd_chk(8'h12, 8'h02);
    wr_reg(8'h0b, 8'h40);
    repeat (2) @(posedge clk);
    #1 check({7'h00, pin}, 8'h01);
    pulse(2);
    #1 check({7'h00, pin}, 8'h00);
    mode <= 1'b1;
    pulse(0);
    #1 check({7'h00, pin}, 8'h01);
    pulse(2);
    #1 check({7'h00, pin}, 8'h01);
    wr_reg(8'h0b, 8'h00);
    wr_reg(8'h0b, 8'h40);
    repeat (2) @(posedge clk);
    #1 check({6'h00, oe, pin}, 8'h02);
    $display("test pin done");
  endtask

  // Reset in mid-run must clear every register and output again
  task automatic t_reset_again;
    wr_reg(8'h0b, 8'h00);
    wr_reg(8'h0b, 8'hef);
    @(posedge clk);
    #1 check({4'h0, oe, pin, low_irq, irq}, 8'h0f);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    #1 check({3'h0, oe, pin, low_irq, irq, strobe}, 8'h00);
    rd_chk(8'h0b, 8'h00);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h11, 8'h00);
    $display("test reset again done");
  endtask

  task automatic complete_run;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The tests need about 130 cycles; this limit only cuts a hang
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    complete_run;
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_mode16;
    t_dual;
    t_capture;
    t_pin;
    t_reset_again;
    complete_run;
  end
endmodule
